// File: core/afr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module afr_ctrl
  import afr_pkg::*;
#(
  parameter int PIX_W = 12 // Pixel data width.
) (
  // Clock, reset and enable.
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Serial write port.
  input  wire logic              ser_load_n,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  // Timing inputs.
  input  wire logic              vertical_sync,
  input  wire logic              update_hold,
  input  wire logic              pixel_blank_window,
  // Substrate-count source candidates.
  input  wire logic              vert_clock_6,
  input  wire logic              vert_clock_8,
  input  wire logic              vert_clock_9,
  input  wire logic              vert_clock_10,
  input  wire logic              vert_clock_13,
  input  wire logic              sensor_gate_1,
  input  wire logic              sensor_gate_2,
  input  wire logic              sensor_gate_3,
  input  wire logic              sensor_gate_4,
  input  wire logic              sensor_gate_5,
  input  wire logic              sensor_gate_6,
  input  wire logic              sensor_gate_7,
  input  wire logic              sensor_gate_8,
  input  wire logic              substrate_bias,
  input  wire logic              mech_shutter,
  input  wire logic              strobe_out,
  // Pixel path.
  input  wire logic [PIX_W-1:0]  pix_in,
  input  wire logic              pix_phase_stb,
  output logic [PIX_W-1:0]       pix_out,
  output logic                   pix_oe,
  // Analog control outputs.
  output afr_pwr_t               power_state,
  output logic                   ob_clamp_on,
  output logic                   clamp_settle_fast,
  output logic                   fast_clamp_pulse,
  output logic                   dc_restore_active,
  output logic                   pixel_out_latch_bypass,
  output afr_smp_gain_t          sampler_gain,
  output logic [GAIN_W-1:0]      amplifier_gain,
  output logic [GAIN_W-1:0]      black_clamp_target,
  output logic                   substrate_count_ctrl
);

  // How the block is put together.
  // A serial receiver turns the three-wire frame into complete words.
  // Each complete word arrives as a one-cycle strobe with address and data.
  // The strobe is decoded against the five registers kept here.
  // Words for any other address are ignored without side effects.
  // Two registers take effect as soon as their word is complete.
  // Three registers are held in pending copies first.
  // The pending copies move to the live outputs at a vertical-sync fall.
  // This keeps a gain change from landing in the middle of a field.
  // The update_hold input postpones that move to a later fall.
  // A pending value is never lost while the move is postponed.
  // Every output of this module comes straight from a flip-flop.
  // Decoded controls therefore trail their register by one edge.
  // A host reading back behaviour must allow for that extra edge.
  // The clock enable freezes every flip-flop, receiver included.
  // While it is low, serial bits and sync edges go unseen until it returns, and then only if their new level is still held.
  // A sync fall that happens while frozen is seen at the first enabled edge if sync is still low.
  // The pixel path is a plain data latch with a blanking override.
  // The substrate-count output is a registered sixteen-way selector.
  // Reserved bits of the output driver register are stored as written.
  // They steer nothing in this block.

  // Live registers.
  logic [PWR_CLAMP_W-1:0] afe_power_and_clamp_ctrl; // Immediate controls.
  logic [OUT_DRV_W-1:0]   output_driver_ctrl;       // Immediate output controls.
  // Pending copies of field-synchronous registers.
  logic [SMP_GAIN_W-1:0]  pend_smp_gain;            // Pending sampler gain.
  logic [GAIN_W-1:0]      pend_amp_gain;            // Pending amplifier gain.
  logic [GAIN_W-1:0]      pend_clamp_tgt;           // Pending clamp target.
  logic                   vsync_q;                  // Previous vertical sync.

  // Serial receiver outputs.
  logic              wr_stb;  // One-cycle complete-word strobe.
  logic [ADDR_W-1:0] wr_addr; // Target address.
  logic [DATA_W-1:0] wr_data; // Received data word.

  // Receiver.
  // It samples the serial clock on clk, so that clock must stay well below clk.
  // Each serial clock level has to last at least one clk cycle to be seen.
  // A word cut short before its last data bit leaves its register unchanged.
  // Further words in one frame go to the next address up in turn.
  // Writing past the last register here is harmless, as unknown addresses drop.
  // The strobe is a single cycle wide, so each word is applied once only.
  // Address and data stay steady after the strobe until the next word.
  afr_serial_rx u_rx (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .ser_load_n (ser_load_n),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .wr_stb     (wr_stb),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data)
  );

  // Address decode.
  wire wr_pwr   = wr_stb && wr_addr == ADDR_PWR_CLAMP;
  wire wr_drv   = wr_stb && wr_addr == ADDR_OUT_DRV;
  wire wr_smp   = wr_stb && wr_addr == ADDR_SMP_GAIN;
  wire wr_amp   = wr_stb && wr_addr == ADDR_AMP_GAIN;
  wire wr_clamp = wr_stb && wr_addr == ADDR_CLAMP_TGT;

  // Field-synchronous apply moment; update_hold postpones it.
  // The sync input is taken as synchronous to clk, so one flip-flop suffices.
  // A fall is seen when the previous level was high and the current is low.
  // The previous level resets low, so a sync held low through reset gives no fall.
  // A sync held high through reset gives a real fall when it first drops.
  // The apply lasts a single cycle, whatever the width of the sync pulse.
  // When held, the pending copies simply wait for a later fall.
  // Several writes before one fall leave only the last value pending.
  wire vsync_fall = vsync_q && !vertical_sync;
  wire apply_vd   = vsync_fall && !update_hold;

  // Amplifier gain actually changes at this apply.
  wire gain_change = apply_vd && pend_amp_gain != amplifier_gain;

  // Field aliases.
  wire       f_clamp_on  = afe_power_and_clamp_ctrl[CLAMP_ON_B];
  wire       f_gain_fast = afe_power_and_clamp_ctrl[GAIN_FAST_B];
  wire       f_blank_lvl = afe_power_and_clamp_ctrl[BLANK_LVL_B];
  wire       f_dc_byp    = afe_power_and_clamp_ctrl[DC_BYP_B];
  wire [3:0] f_src       = afe_power_and_clamp_ctrl[SRC_HI:SRC_LO];
  wire       f_tristate  = output_driver_ctrl[TRISTATE_B];
  wire       f_latch_byp = output_driver_ctrl[LATCH_BYP_B];

  // Blanking value: zero or the top bits of the clamp target.
  wire [PIX_W-1:0] blank_val = f_blank_lvl ?
    PIX_W'(black_clamp_target >> 2) : '0;
  wire [PIX_W-1:0] pix_sel = pixel_blank_window ? blank_val : pix_in;
  // Latch on output phase unless transparent.
  wire             pix_load = f_latch_byp || pix_phase_stb;

  // Substrate-count candidates in code order.
  wire [15:0] sub_src = {strobe_out, mech_shutter, substrate_bias, vert_clock_13,
                         sensor_gate_1, sensor_gate_4, sensor_gate_3, sensor_gate_2,
                         sensor_gate_8, sensor_gate_7, sensor_gate_6, sensor_gate_5,
                         vert_clock_10, vert_clock_9, vert_clock_8, vert_clock_6};

  // Substrate-count selector.
  // The selection code is read from the live register every cycle.
  // A code change mid-line switches the output at once, one edge late.
  // Glitches on a candidate pass through, delayed by one clock.
  // The selector has no notion of which candidate is sensible to use.
  // All sixteen codes are legal, so no code is refused here.
  afr_sub_mux u_sub (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .sel     (f_src),
    .src     (sub_src),
    .sub_out (substrate_count_ctrl)
  );

  // Immediate registers load on the strobe, one edge after the last data bit is taken.
  // The whole word below the register width is stored as written.
  // Upper data bits beyond the width are dropped here on purpose.
  // A host that leaves them nonzero sees no effect in this block.
  // Power state and clamp bits act at the next edge through the decode stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      afe_power_and_clamp_ctrl <= RST_PWR_CLAMP;
      output_driver_ctrl       <= RST_OUT_DRV;
    end else if (ce) begin
      if (wr_pwr) begin
        afe_power_and_clamp_ctrl <= wr_data[PWR_CLAMP_W-1:0];
      end
      if (wr_drv) begin
        output_driver_ctrl <= wr_data[OUT_DRV_W-1:0];
      end
    end
  end

  // Pending copies capture writes to field-synchronous registers.
  // A write and an apply in the same cycle both happen.
  // The apply then moves the older pending value out.
  // The newly written value waits for the following fall.
  // This keeps each field built from one consistent set of values.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_smp_gain  <= RST_SMP_GAIN;
      pend_amp_gain  <= RST_AMP_GAIN;
      pend_clamp_tgt <= RST_CLAMP_TGT;
    end else if (ce) begin
      if (wr_smp) begin
        pend_smp_gain <= wr_data[SMP_GAIN_W-1:0];
      end
      if (wr_amp) begin
        pend_amp_gain <= wr_data[GAIN_W-1:0];
      end
      if (wr_clamp) begin
        pend_clamp_tgt <= wr_data[GAIN_W-1:0];
      end
    end
  end

  // Active field-synchronous values transfer at the vertical-sync fall.
  // All three values move together so gain and clamp stay matched.
  // An apply with unchanged pending values leaves the outputs as they are.
  // The sync history register also lives here, as it shares the enable.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vsync_q            <= 1'b0;
      sampler_gain       <= afr_smp_gain_t'(RST_SMP_GAIN);
      amplifier_gain     <= RST_AMP_GAIN;
      black_clamp_target <= RST_CLAMP_TGT;
    end else if (ce) begin
      vsync_q <= vertical_sync;
      if (apply_vd) begin
        sampler_gain       <= afr_smp_gain_t'(pend_smp_gain);
        amplifier_gain     <= pend_amp_gain;
        black_clamp_target <= pend_clamp_tgt;
      end
    end
  end

  // Decoded analog controls, registered.
  // The fast clamp pulse needs the clamp loop enabled to mean anything.
  // It fires only when the amplifier gain value really changes.
  // The dc-restore control follows the blanking window one edge late while the bypass bit is clear.
  // The output enable is the inverse of the three-state bit, high to drive.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_state            <= afr_pwr_t'(RST_PWR_CLAMP[PWR_HI:PWR_LO]);
      ob_clamp_on            <= RST_PWR_CLAMP[CLAMP_ON_B];
      clamp_settle_fast      <= RST_PWR_CLAMP[SETTLE_B];
      fast_clamp_pulse       <= 1'b0;
      dc_restore_active      <= 1'b0;
      pixel_out_latch_bypass <= RST_OUT_DRV[LATCH_BYP_B];
      pix_oe                 <= ~RST_OUT_DRV[TRISTATE_B];
    end else if (ce) begin
      power_state            <= afr_pwr_t'(afe_power_and_clamp_ctrl[PWR_HI:PWR_LO]);
      ob_clamp_on            <= f_clamp_on;
      clamp_settle_fast      <= afe_power_and_clamp_ctrl[SETTLE_B];
      fast_clamp_pulse       <= f_clamp_on && f_gain_fast && gain_change;
      dc_restore_active      <= pixel_blank_window && !f_dc_byp;
      pixel_out_latch_bypass <= f_latch_byp;
      pix_oe                 <= ~f_tristate;
    end
  end

  // Output data latch.
  // When transparent, the latch loads every enabled cycle.
  // Otherwise it loads only on the output phase strobe.
  // Blanking replaces the input value before the latch, not after it.
  // The latch keeps loading while the drivers are three-stated.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pix_out <= '0;
    end else if (ce && pix_load) begin
      pix_out <= pix_sel;
    end
  end

endmodule // afr_ctrl
`default_nettype wire

// File: core/afr_pkg.sv
package afr_pkg;

  // Serial word layout.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 28;
  localparam int WORD_W = 40;
  localparam int CNT_W  = 6;

  // Register addresses.
  localparam logic [11:0] ADDR_PWR_CLAMP = 12'h000;
  localparam logic [11:0] ADDR_OUT_DRV   = 12'h001;
  localparam logic [11:0] ADDR_SMP_GAIN  = 12'h004;
  localparam logic [11:0] ADDR_AMP_GAIN  = 12'h005;
  localparam logic [11:0] ADDR_CLAMP_TGT = 12'h006;

  // Field positions in the power and clamp control register.
  localparam int PWR_LO      = 0;
  localparam int PWR_HI      = 1;
  localparam int CLAMP_ON_B  = 2;
  localparam int SETTLE_B    = 3;
  localparam int GAIN_FAST_B = 4;
  localparam int BLANK_LVL_B = 5;
  localparam int DC_BYP_B    = 6;
  localparam int SRC_LO      = 11;
  localparam int SRC_HI      = 14;

  // Field positions in the output driver register.
  localparam int TRISTATE_B  = 0;
  localparam int LATCH_BYP_B = 1;

  // Widths of the register contents.
  localparam int PWR_CLAMP_W = 15;
  localparam int OUT_DRV_W   = 4;
  localparam int SMP_GAIN_W  = 2;
  localparam int GAIN_W      = 10;

  // Reset values.
  localparam logic [14:0] RST_PWR_CLAMP = 15'h0007;
  localparam logic [3:0]  RST_OUT_DRV   = 4'h8;
  localparam logic [1:0]  RST_SMP_GAIN  = 2'h1;
  localparam logic [9:0]  RST_AMP_GAIN  = 10'h00f;
  localparam logic [9:0]  RST_CLAMP_TGT = 10'h1ec;

  // Power states.
  typedef enum logic [1:0] {
    AFR_PWR_NORMAL,
    AFR_PWR_STBY1,
    AFR_PWR_STBY2,
    AFR_PWR_STBY3
  } afr_pwr_t;

  // Sampler gain settings.
  typedef enum logic [1:0] {
    AFR_SG_M3DB,
    AFR_SG_0DB,
    AFR_SG_P3DB,
    AFR_SG_P6DB
  } afr_smp_gain_t;

endpackage

// File: core/afr_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Serial receiver: collects address then 28-bit words, auto-incrementing.
module afr_serial_rx
  import afr_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Serial pins, sampled on clk.
  input  wire logic              ser_load_n,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  // Completed word.
  output logic                   wr_stb,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [DATA_W-1:0]      wr_data
);

  logic              sck_q;     // Previous serial clock level.
  logic [CNT_W-1:0]  bit_cnt;   // Bits received in the current field.
  logic              have_addr; // Address phase complete.
  logic [ADDR_W-1:0] addr_sr;   // Address shift register.
  logic [DATA_W-1:0] data_sr;   // Data shift register.

  wire sck_rise = ser_clk & ~sck_q;
  wire active   = ~ser_load_n;
  wire addr_end = !have_addr && bit_cnt == CNT_W'(ADDR_W - 1);
  wire data_end = have_addr && bit_cnt == CNT_W'(DATA_W - 1);

  // Shift LSB first; a partial word is dropped when load rises.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_q     <= 1'b0;
      bit_cnt   <= '0;
      have_addr <= 1'b0;
      addr_sr   <= '0;
      data_sr   <= '0;
      wr_stb    <= 1'b0;
      wr_addr   <= '0;
      wr_data   <= '0;
    end else if (ce) begin
      sck_q  <= ser_clk;
      wr_stb <= 1'b0;
      if (!active) begin
        // Frame ended; any short word is discarded.
        bit_cnt   <= '0;
        have_addr <= 1'b0;
      end else if (sck_rise) begin
        if (!have_addr) begin
          addr_sr <= {ser_data, addr_sr[ADDR_W-1:1]};
          bit_cnt <= addr_end ? '0 : bit_cnt + CNT_W'(1);
          if (addr_end) begin
            have_addr <= 1'b1;
          end
        end else begin
          data_sr <= {ser_data, data_sr[DATA_W-1:1]};
          bit_cnt <= data_end ? '0 : bit_cnt + CNT_W'(1);
          if (data_end) begin
            // Full word: emit and step to next address.
            wr_stb  <= 1'b1;
            wr_addr <= addr_sr;
            wr_data <= {ser_data, data_sr[DATA_W-1:1]};
            addr_sr <= addr_sr + ADDR_W'(1);
          end
        end
      end
    end
  end

endmodule // afr_serial_rx
`default_nettype wire

// File: core/afr_sub_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Substrate-count source selector, registered.
module afr_sub_mux
  import afr_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Selection and candidate sources.
  input  wire logic [3:0] sel,
  input  wire logic [15:0] src,
  // Selected signal.
  output logic            sub_out
);

  // Indexed selection of the sixteen candidates.
  wire picked = src[sel];

  // Register the pick so the output comes from a flip-flop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sub_out <= 1'b0;
    end else if (ce) begin
      sub_out <= picked;
    end
  end

endmodule // afr_sub_mux
`default_nettype wire

// File: testbench/afr_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// Checker: ties output changes, except clamp_settle_fast and substrate_count_ctrl, to their serial, sync or pixel cause.
module afr_ctrl_props
  import afr_pkg::*;
#(
  parameter int PIX_W = 12 // Pixel data width.
) (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              rst,
  // Causes.
  input wire logic              ser_load_n,
  input wire logic              vertical_sync,
  input wire logic              pixel_blank_window,
  input wire logic [PIX_W-1:0]  pix_in,
  input wire logic              pix_phase_stb,
  // Effects.
  input wire logic [PIX_W-1:0]  pix_out,
  input wire logic              pix_oe,
  input wire afr_pwr_t          power_state,
  input wire logic              ob_clamp_on,
  input wire logic              fast_clamp_pulse,
  input wire logic              dc_restore_active,
  input wire logic              pixel_out_latch_bypass,
  input wire afr_smp_gain_t     sampler_gain,
  input wire logic [GAIN_W-1:0] amplifier_gain,
  input wire logic [GAIN_W-1:0] black_clamp_target
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A sync fall, seen one edge after it was detected.
  sequence fell_seen;
    $past(vertical_sync, 2) && !$past(vertical_sync);
  endsequence
  a_smp_gain_field: assert property ($changed(sampler_gain) |-> fell_seen)
    else $error("sampler gain moved without a sync fall");
  a_amp_gain_field: assert property ($changed(amplifier_gain) |-> fell_seen)
    else $error("amplifier gain moved without a sync fall");
  a_clamp_tgt_field: assert property ($changed(black_clamp_target) |-> fell_seen)
    else $error("clamp target moved without a sync fall");
  a_imm_serial_cause: assert property ($changed({power_state, ob_clamp_on, pix_oe,
    pixel_out_latch_bypass}) |-> !$past(ser_load_n, 3))
    else $error("immediate field moved outside a serial frame");
  a_dc_only_blank: assert property (dc_restore_active |-> $past(pixel_blank_window))
    else $error("dc restore active outside blanking");
  // The registered bypass output lags the live field by one edge, which matches the load.
  a_pix_pass_thru: assert property ($past(!pixel_blank_window) && pixel_out_latch_bypass
    |-> pix_out == $past(pix_in))
    else $error("transparent output did not follow input");
  a_pix_blank_level: assert property ($past(pixel_blank_window) &&
    (pixel_out_latch_bypass || $past(pix_phase_stb)) |-> pix_out == '0 ||
    pix_out == PIX_W'($past(black_clamp_target) >> 2))
    else $error("blanked output is neither zero nor clamp level");
  a_fast_pulse_once: assert property (fast_clamp_pulse |=> !fast_clamp_pulse)
    else $error("fast clamp pulse longer than one cycle");
  a_fast_pulse_cause: assert property (fast_clamp_pulse |-> ob_clamp_on &&
    ($changed(amplifier_gain) || $past(amplifier_gain) != $past(amplifier_gain, 2)))
    else $error("fast clamp pulse without a gain change");
endmodule // afr_ctrl_props
bind afr_ctrl afr_ctrl_props #(.PIX_W(PIX_W)) afr_ctrl_props_inst (.clk, .rst, .ser_load_n,
  .vertical_sync, .pixel_blank_window, .pix_in, .pix_phase_stb, .pix_out, .pix_oe,
  .power_state, .ob_clamp_on, .fast_clamp_pulse, .dc_restore_active,
  .pixel_out_latch_bypass, .sampler_gain, .amplifier_gain, .black_clamp_target);
`default_nettype wire

// File: testbench/afr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host model of the three-wire write port; the serial clock idles low.
module afr_host_model (
  // Clock.
  input  wire logic clk,
  // Serial write pins.
  output logic      ser_load_n,
  output logic      ser_clk,
  output logic      ser_data
);
  // Frame closed at time zero.
  initial begin
    ser_load_n = 1'b1;
    ser_clk    = 1'b0;
    ser_data   = 1'b0;
  end
  // Sends n bits of w least significant first; s stretches each phase.
  task automatic send(input logic [67:0] w, input int n, input int s);
    @(negedge clk);
    ser_load_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      ser_clk  = 1'b0;
      ser_data = w[k]; // Unused data bits arrive as zeros.
      repeat (1 + s) @(negedge clk);
      ser_clk = 1'b1;
      repeat (1 + s) @(negedge clk);
    end
    ser_clk = 1'b0;
    @(negedge clk);
    ser_load_n = 1'b1;
    ser_data   = ~ser_data; // The released line does not keep its last value.
  endtask
endmodule // afr_host_model
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: writes registers through the host model and checks the outputs.
module testbench
  import afr_pkg::*;
;
  // Stimulus.
  logic clk = 1'b0, rst = 1'b1, vertical_sync = 1'b0, update_hold = 1'b0;
  logic pixel_blank_window = 1'b0, pix_phase_stb = 1'b1;
  logic [15:0] src = 16'h0001;
  logic [11:0] pix_in = 12'h5a3;
  // Observed outputs.
  wire logic ser_load_n, ser_clk, ser_data, pix_oe, ob_clamp_on, clamp_settle_fast;
  wire logic fast_clamp_pulse, dc_restore_active, pixel_out_latch_bypass;
  wire logic substrate_count_ctrl;
  wire logic [11:0] pix_out;
  wire logic [9:0] amplifier_gain, black_clamp_target;
  wire afr_pwr_t power_state;
  wire afr_smp_gain_t sampler_gain;
  int checked = 0, n_fail = 0;
  int np;
  // Clock.
  always #2 clk = ~clk;
  afr_host_model afr_host_model_inst (.clk, .ser_load_n, .ser_clk, .ser_data);
  afr_ctrl #(.PIX_W(12)) afr_ctrl_inst (.clk, .rst, .ce(1'b1), .ser_load_n, .ser_clk,
    .ser_data, .vertical_sync, .update_hold, .pixel_blank_window, .pix_in, .pix_phase_stb,
    .vert_clock_6(src[0]), .vert_clock_8(src[1]), .vert_clock_9(src[2]),
    .vert_clock_10(src[3]), .sensor_gate_5(src[4]), .sensor_gate_6(src[5]),
    .sensor_gate_7(src[6]), .sensor_gate_8(src[7]), .sensor_gate_2(src[8]),
    .sensor_gate_3(src[9]), .sensor_gate_4(src[10]), .sensor_gate_1(src[11]),
    .vert_clock_13(src[12]), .substrate_bias(src[13]), .mech_shutter(src[14]),
    .strobe_out(src[15]), .pix_out, .pix_oe, .power_state, .ob_clamp_on,
    .clamp_settle_fast, .fast_clamp_pulse, .dc_restore_active, .pixel_out_latch_bypass,
    .sampler_gain, .amplifier_gain, .black_clamp_target, .substrate_count_ctrl);
  // Compares one value and counts it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One write, then the fixed four-edge delay before outputs settle.
  task automatic wr(input logic [67:0] w, input int n = 40, input int s = 0);
    afr_host_model_inst.send(w, n, s);
    repeat (4) @(negedge clk);
  endtask
  // Sync pulse; counts fast clamp pulses after the fall.
  task automatic vs(input logic h);
    update_hold   = h;
    vertical_sync = 1'b1;
    np            = 0;
    repeat (2) @(negedge clk);
    vertical_sync = 1'b0;
    repeat (6) begin
      @(negedge clk);
      if (fast_clamp_pulse === 1'b1) np++;
    end
    update_hold = 1'b0;
  endtask
  // Prints the counts and the verdict.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard.
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  // Main sequence.
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({power_state, ob_clamp_on, clamp_settle_fast, pix_oe, pixel_out_latch_bypass},
      16'h3a);
    chk({sampler_gain, amplifier_gain}, {2'h1, 10'h00f});
    chk(black_clamp_target, 16'h01ec);
    chk(substrate_count_ctrl, 16'h1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      wr({13'h0, i[3:0], 7'h0, i[1], i[0], i[1:0], 12'h000}, 40, i % 2);
      src = 16'h0001 << i;
      repeat (2) @(negedge clk);
      chk(substrate_count_ctrl, 16'h1);
      src = ~src;
      repeat (2) @(negedge clk);
      chk(substrate_count_ctrl, 16'h0);
      chk({power_state, ob_clamp_on, clamp_settle_fast}, {i[1:0], i[0], i[1]});
    end
    $display("test immediate fields done");
    wr({28'h34, 12'h000});
    pixel_blank_window = 1'b1;
    repeat (2) @(negedge clk);
    chk(dc_restore_active, 16'h1);
    chk(pix_out, 16'h07b);
    wr({28'h44, 12'h000});
    chk(dc_restore_active, 16'h0);
    chk(pix_out, 16'h0);
    pixel_blank_window = 1'b0;
    repeat (2) @(negedge clk);
    chk(pix_out, 16'h5a3);
    $display("test blanking done");
    wr({28'h9, 12'h001}); // Reserved bits kept at their fixed values.
    chk(pix_oe, 16'h0);
    wr({28'ha, 12'h001});
    chk({pix_oe, pixel_out_latch_bypass}, 16'h3);
    pix_phase_stb = 1'b0;
    pix_in        = 12'h3c6;
    repeat (2) @(negedge clk);
    chk(pix_out, 16'h3c6);
    wr({28'h8, 12'h001});
    pix_in = 12'h111;
    repeat (2) @(negedge clk);
    chk(pix_out, 16'h3c6);
    pix_phase_stb = 1'b1;
    $display("test output driver done");
    wr({28'h14, 12'h000});
    wr({28'h0, 28'h3ff, 12'h005}, 68);
    wr({28'h3, 12'h004});
    chk({sampler_gain, amplifier_gain}, {2'h1, 10'h00f});
    vs(1'b1);
    chk(black_clamp_target, 16'h01ec);
    chk(np, 16'h0);
    vs(1'b0);
    chk({sampler_gain, amplifier_gain}, {2'h3, 10'h3ff});
    chk(black_clamp_target, 16'h0);
    chk(np, 16'h1);
    wr({28'h04, 12'h000});
    wr({28'h200, 12'h005});
    vs(1'b0);
    chk(amplifier_gain, 16'h200);
    chk(np, 16'h0);
    $display("test field update done");
    wr({28'h3, 12'h000}, 39);
    wr({28'h3, 12'h002});
    chk({power_state, sampler_gain}, 16'h3);
    $display("test refused writes done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
